// file: src/erb_map.svh
// constants of the embedded ram block: offsets, fields, reset values
`ifndef ERB_MAP_SVH
`define ERB_MAP_SVH
`define ERB_OFS_CFG 4'h0
`define ERB_OFS_STAT 4'h4
`define ERB_CFG_KIND_LSB 0
`define ERB_CFG_SDP 2
`define ERB_CFG_ECC 3
`define ERB_CFG_PAR9 4
`define ERB_CFG_WCODE_LSB 5
`define ERB_CFG_RCODE_LSB 7
`define ERB_CFG_OUTREG 9
`define ERB_CFG_STATREG 10
`define ERB_CFG_RDW_LSB 11
`define ERB_CFG_RST 32'h0000_0000
`define ERB_ST_ECCACT 0
`define ERB_ST_BAD 1
`define ERB_ST_CORR 2
`define ERB_ST_DBL 3
`define ERB_STAT_OK 3'h0
`define ERB_STAT_FIX 3'h3
`define ERB_STAT_DBL 3'h5
`define ERB_DC_FILL 72'h00_0000_0000_0000_0000
`define ERB_WORDS 2048
`define ERB_LANES 8
`endif

// file: src/erb_pkg.sv
// types of the embedded ram block
package erb_pkg;
  typedef enum logic [1:0] {ERB_SMALL, ERB_MEDIUM, ERB_LARGE, ERB_KIND_RSVD} erb_kind_t;
  typedef enum logic [1:0] {ERB_RDW_DC, ERB_RDW_OLD, ERB_RDW_NEW, ERB_RDW_RSVD} erb_rdw_t;
  typedef struct packed {
    erb_rdw_t rdw;
    logic statReg;
    logic outReg;
    logic [1:0] rCode;
    logic [1:0] wCode;
    logic par9;
    logic eccEn;
    logic sdp;
    erb_kind_t kind;
  } erb_cfg_t;
endpackage : erb_pkg

// file: src/erb_ram_top.sv
// embedded ram block with mixed widths, read-during-write options and secded
`timescale 1ns/10ps
`include "erb_map.svh"
module erb_ram_top
  import erb_pkg::*;
(
  input wire logic refClkUnused,
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic outClr,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData,
  input wire logic wrEn,
  input wire logic [13:0] wrAddr,
  input wire logic [71:0] wrData,
  input wire logic [7:0] wrByteEn,
  input wire logic rdEn,
  input wire logic [13:0] rdAddr,
  output logic [71:0] rdData,
  output logic [2:0] eccStatus
);
  logic [71:0] mem [`ERB_WORDS];
  erb_cfg_t cfg_reg, cfg_next;
  logic corr_reg, corr_next, dbl_reg, dbl_next;
  logic [31:0] regRdData_reg, regRdData_next;
  logic [71:0] s0Word_reg, s0Word_next;
  logic s0Valid_reg, s0Valid_next, s0Ecc_reg, s0Ecc_next;
  logic [2:0] s0Slice_reg, s0Slice_next;
  logic [71:0] latchData_reg, latchData_next, rdData_reg, rdData_next;
  logic [2:0] latchStat_reg, latchStat_next, statQ_reg;
  logic eccActive, cfgBad, flow, effRdEn, collide;
  erb_rdw_t rdwEff;
  logic [10:0] wWord, rWord;
  logic [2:0] wSlice, rSlice;
  logic [71:0] curW, merged, rawNow, decData;
  logic [2:0] decStat;

  function automatic logic [71:0] eccEncode(input logic [63:0] d);
    logic [71:0] c;
    int k;
    c = '0;
    k = 0;
    for (int p = 1; p < 72; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p] = d[k];
        k++;
      end
    end
    for (int b = 0; b < 7; b++) begin
      for (int p = 1; p < 72; p++) begin
        if (((p >> b) & 1) == 1 && p != (1 << b)) c[1 << b] = c[1 << b] ^ c[p];
      end
    end
    c[0] = ^c[71:1];
    return c;
  endfunction : eccEncode

  function automatic logic [66:0] eccDecode(input logic [71:0] c);
    logic [6:0] syn;
    logic ov;
    logic [71:0] f;
    logic [63:0] d;
    logic [2:0] st;
    int k;
    syn = '0;
    d = '0;
    k = 0;
    for (int b = 0; b < 7; b++) begin
      for (int p = 1; p < 72; p++) begin
        if (((p >> b) & 1) == 1) syn[b] = syn[b] ^ c[p];
      end
    end
    ov = ^c;
    f = c;
    if (!ov && syn == 7'h00) begin
      st = `ERB_STAT_OK;
    end else if (ov && syn < 7'h48) begin
      f[syn] = ~f[syn];
      st = `ERB_STAT_FIX;
    end else begin
      st = `ERB_STAT_DBL;
      f = c;
    end
    for (int p = 1; p < 72; p++) begin
      if ((p & (p - 1)) != 0) begin
        d[k] = f[p];
        k++;
      end
    end
    return {st, d};
  endfunction : eccDecode

  // user lanes to internal 9-bit lanes, lane j to lane j, no slice placement
  function automatic logic [71:0] laneIn(input logic [71:0] u, input logic par9);
    logic [71:0] r;
    for (int j = 0; j < `ERB_LANES; j++) begin
      r[j * 9 +: 9] = par9 ? u[j * 9 +: 9] : {1'b0, u[j * 8 +: 8]};
    end
    return r;
  endfunction : laneIn

  function automatic logic [71:0] laneOut(input logic [71:0] w, input logic [2:0] sl,
                                          input logic [1:0] code, input logic par9);
    logic [71:0] r;
    int base;
    r = '0;
    base = int'(sl) << code;
    for (int j = 0; j < `ERB_LANES; j++) begin
      if (j < (1 << code)) begin
        if (par9) r[j * 9 +: 9] = w[(base + j) * 9 +: 9];
        else r[j * 8 +: 8] = w[(base + j) * 9 +: 8];
      end
    end
    return r;
  endfunction : laneOut

  // configuration legality and derived modes
  always_comb begin
    eccActive = cfg_reg.eccEn && cfg_reg.kind == ERB_LARGE && cfg_reg.sdp && !cfg_reg.par9
      && cfg_reg.wCode == 2'h3 && cfg_reg.rCode == 2'h3;
    cfgBad = 1'b0;
    unique case (cfg_reg.kind)
      ERB_SMALL: cfgBad = cfg_reg.wCode > 2'h1 || cfg_reg.rCode > 2'h1;
      ERB_MEDIUM: cfgBad = cfg_reg.wCode > 2'h2 || cfg_reg.rCode > 2'h2;
      ERB_LARGE: cfgBad = !cfg_reg.sdp && cfg_reg.wCode != cfg_reg.rCode;
      default: cfgBad = 1'b1;
    endcase
    if (!cfg_reg.sdp && cfg_reg.wCode != cfg_reg.rCode) cfgBad = 1'b1;
    flow = cfg_reg.kind == ERB_SMALL;
    effRdEn = flow ? 1'b1 : rdEn;
    rdwEff = cfg_reg.rdw;
    if (cfg_reg.rdw == ERB_RDW_RSVD) rdwEff = ERB_RDW_DC;
    if (eccActive && cfg_reg.rdw == ERB_RDW_OLD) rdwEff = ERB_RDW_DC;
    if ((cfg_reg.sdp || flow) && cfg_reg.rdw == ERB_RDW_NEW) rdwEff = ERB_RDW_DC;
  end

  // write merge and read source
  always_comb begin
    wWord = 11'((wrAddr >> (2'h3 - cfg_reg.wCode)) & 14'h07FF);
    wSlice = 3'(wrAddr & ((14'h0001 << (2'h3 - cfg_reg.wCode)) - 14'h0001));
    rWord = cfg_reg.sdp ? 11'((rdAddr >> (2'h3 - cfg_reg.rCode)) & 14'h07FF) : wWord;
    rSlice = cfg_reg.sdp ? 3'(rdAddr & ((14'h0001 << (2'h3 - cfg_reg.rCode)) - 14'h0001))
      : wSlice;
    curW = mem[wWord];
    merged = curW;
    if (eccActive) begin
      merged = eccEncode(wrData[63:0]);
    end else begin
      for (int j = 0; j < `ERB_LANES; j++) begin
        if ((j >> cfg_reg.wCode) == int'(wSlice)
            && wrByteEn[j - (int'(wSlice) << cfg_reg.wCode)]) begin
          merged[j * 9 +: 9] =
            laneIn(wrData, cfg_reg.par9)[(j - (int'(wSlice) << cfg_reg.wCode)) * 9 +: 9];
        end
      end
    end
    collide = wrEn && !cfgBad && wWord == rWord;
    rawNow = mem[rWord];
    if (collide) begin
      unique case (rdwEff)
        ERB_RDW_OLD: rawNow = mem[rWord];
        ERB_RDW_NEW: rawNow = merged;
        default: rawNow = `ERB_DC_FILL;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (wrEn && !cfgBad) mem[wWord] <= merged;
  end

  // first read stage: read word and slice registered
  always_comb begin
    s0Valid_next = effRdEn && !cfgBad && !flow;
    s0Word_next = effRdEn ? rawNow : s0Word_reg;
    s0Slice_next = rSlice;
    s0Ecc_next = eccActive;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s0Valid_reg <= 1'b0;
      s0Word_reg <= '0;
      s0Slice_reg <= 3'h0;
      s0Ecc_reg <= 1'b0;
    end else begin
      s0Valid_reg <= s0Valid_next;
      s0Word_reg <= s0Word_next;
      s0Slice_reg <= s0Slice_next;
      s0Ecc_reg <= s0Ecc_next;
    end
  end

  // output latch, output register and status
  always_comb begin
    {decStat, decData[63:0]} = eccDecode(s0Word_reg);
    decData[71:64] = 8'h00;
    latchData_next = latchData_reg;
    latchStat_next = latchStat_reg;
    if (flow && effRdEn && !cfgBad) begin
      latchData_next = laneOut(rawNow, rSlice, cfg_reg.rCode, cfg_reg.par9);
      latchStat_next = `ERB_STAT_OK;
    end else if (s0Valid_reg) begin
      latchData_next = s0Ecc_reg ? decData
        : laneOut(s0Word_reg, s0Slice_reg, cfg_reg.rCode, cfg_reg.par9);
      latchStat_next = s0Ecc_reg ? decStat : `ERB_STAT_OK;
    end
    rdData_next = cfg_reg.outReg ? latchData_reg : latchData_next;
  end

  always_ff @(posedge ref_clk or negedge reset_n or posedge outClr) begin
    if (!reset_n) begin
      latchData_reg <= '0;
      rdData_reg <= '0;
      statQ_reg <= 3'h0;
    end else if (outClr) begin
      latchData_reg <= '0;
      rdData_reg <= '0;
      statQ_reg <= 3'h0;
    end else begin
      latchData_reg <= latchData_next;
      rdData_reg <= rdData_next;
      statQ_reg <= latchStat_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) latchStat_reg <= 3'h0;
    else latchStat_reg <= latchStat_next;
  end

  assign rdData = rdData_reg;
  assign eccStatus = cfg_reg.statReg ? statQ_reg : latchStat_reg;

  // register port
  always_comb begin
    cfg_next = cfg_reg;
    corr_next = corr_reg;
    dbl_next = dbl_reg;
    if (regWrite && regAddr == `ERB_OFS_CFG) cfg_next = erb_cfg_t'(regWrData[12:0]);
    if (regWrite && regAddr == `ERB_OFS_STAT) begin
      if (regWrData[`ERB_ST_CORR]) corr_next = 1'b0;
      if (regWrData[`ERB_ST_DBL]) dbl_next = 1'b0;
    end
    if (s0Valid_reg && s0Ecc_reg && decStat == `ERB_STAT_FIX) corr_next = 1'b1;
    if (s0Valid_reg && s0Ecc_reg && decStat == `ERB_STAT_DBL) dbl_next = 1'b1;
    regRdData_next = 32'h0000_0000;
    if (regRead && regAddr == `ERB_OFS_CFG) regRdData_next = {19'h0_0000, cfg_reg};
    if (regRead && regAddr == `ERB_OFS_STAT) begin
      regRdData_next = {28'h000_0000, dbl_reg, corr_reg, cfgBad, eccActive};
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_reg <= erb_cfg_t'(`ERB_CFG_RST);
      corr_reg <= 1'b0;
      dbl_reg <= 1'b0;
      regRdData_reg <= 32'h0000_0000;
    end else begin
      cfg_reg <= cfg_next;
      corr_reg <= corr_next;
      dbl_reg <= dbl_next;
      regRdData_reg <= regRdData_next;
    end
  end

  assign regRdData = regRdData_reg;

  // checks
  sequence eccRead;
    s0Valid_reg && s0Ecc_reg;
  endsequence
  sequence dblSeen;
    eccRead ##0 decStat == `ERB_STAT_DBL;
  endsequence

  AST_ECC_ONLY_64: assert property (@(posedge ref_clk) disable iff (!reset_n)
    eccActive |-> cfg_reg.kind == ERB_LARGE && cfg_reg.sdp && cfg_reg.wCode == 2'h3)
    else $error("correction engaged outside 64-bit dual-port");
  AST_STAT_LEGAL: assert property (@(posedge ref_clk) disable iff (!reset_n)
    eccStatus == 3'h0 || eccStatus == 3'h3 || eccStatus == 3'h5)
    else $error("illegal status code");
  AST_DBL_CODE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    dblSeen |=> latchStat_reg == `ERB_STAT_DBL && latchData_reg == $past(decData))
    else $error("double error not reported");
  AST_STAT_REG_DELAY: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !outClr && !$past(outClr) |-> statQ_reg == $past(latchStat_reg))
    else $error("registered status misaligned");
  AST_CLR_NO_UNREG: assert property (@(posedge ref_clk) disable iff (!reset_n)
    outClr && !s0Valid_reg && !flow |=> latchStat_reg == $past(latchStat_reg))
    else $error("clear touched unregistered status");
  AST_NO_OLD_ECC: assert property (@(posedge ref_clk) disable iff (!reset_n)
    eccActive |-> rdwEff != ERB_RDW_OLD)
    else $error("old data with correction");
  AST_HOLD: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !effRdEn && !s0Valid_reg ##1 !outClr && !s0Valid_reg |-> $stable(latchData_reg))
    else $error("outputs moved without read");
  AST_OUT_LATENCY: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cfg_reg.outReg && $stable(cfg_reg) && !outClr && !$past(outClr)
      |-> rdData_reg == $past(latchData_reg))
    else $error("registered output latency wrong");
  AST_READ_STAGE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    rdEn && !flow && !cfgBad |=> s0Valid_reg)
    else $error("read not registered");
  AST_SMALL_NO_NEW: assert property (@(posedge ref_clk) disable iff (!reset_n)
    flow |-> rdwEff != ERB_RDW_NEW)
    else $error("small block returned new data");
endmodule : erb_ram_top

// file: bench/erb_fabric_model.sv
// fabric-side user logic that drives the ram ports
`timescale 1ns/10ps
module erb_fabric_model (
  input wire logic ref_clk,
  input wire logic [71:0] rdData,
  input wire logic [2:0] eccStatus,
  output logic wrEn,
  output logic [13:0] wrAddr,
  output logic [71:0] wrData,
  output logic [7:0] wrByteEn,
  output logic rdEn,
  output logic [13:0] rdAddr
);
  initial begin
    wrEn = 1'b0;
    wrAddr = 14'h0;
    wrData = 72'h0;
    wrByteEn = 8'hFF;
    rdEn = 1'b0;
    rdAddr = 14'h0;
  end
  // one cycle of requests, result taken lag edges after the taking edge
  task automatic access(input logic we, input logic re, input logic [13:0] wa,
      input logic [71:0] wd, input logic [13:0] ra, input int lag,
      output logic [71:0] d, output logic [2:0] s);
    @(posedge ref_clk);
    wrEn <= we;
    wrAddr <= wa;
    wrData <= wd;
    rdEn <= re;
    rdAddr <= ra;
    @(posedge ref_clk);
    wrEn <= 1'b0;
    rdEn <= 1'b0;
    wrData <= ~wd;
    repeat (lag) @(posedge ref_clk);
    #1;
    d = rdData;
    s = eccStatus;
  endtask : access
endmodule : erb_fabric_model

// file: bench/erb_ram_top_test.sv
// self-checking bench of the embedded ram block
`timescale 1ns/10ps
module erb_ram_top_test;
  localparam logic [31:0] ECC = 32'h0000_01EE;
  localparam logic [71:0] DW = 72'h00_0123_4567_89AB_CDEF;
  localparam logic [71:0] DE = 72'h00_FEDC_BA98_7654_3210;
  logic ref_clk, reset_n, outClr, regWrite, regRead, wrEn, rdEn;
  logic [3:0] regAddr;
  logic [31:0] regWrData, regRdData, r;
  logic [71:0] wrData, rdData, d, cw;
  logic [7:0] wrByteEn;
  logic [13:0] wrAddr, rdAddr;
  logic [2:0] eccStatus, s;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;
  erb_ram_top i_erb_ram_top (.refClkUnused(1'b0), .ref_clk(ref_clk), .reset_n(reset_n),
    .outClr(outClr), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData), .wrEn(wrEn), .wrAddr(wrAddr),
    .wrData(wrData), .wrByteEn(wrByteEn), .rdEn(rdEn), .rdAddr(rdAddr),
    .rdData(rdData), .eccStatus(eccStatus));
  erb_fabric_model i_erb_fabric_model (.ref_clk(ref_clk), .rdData(rdData),
    .eccStatus(eccStatus), .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData),
    .wrByteEn(wrByteEn), .rdEn(rdEn), .rdAddr(rdAddr));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= v;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1;
    v = regRdData;
  endtask : reg_rd
  task automatic acc(input logic we, input logic re, input logic [13:0] wa,
      input logic [71:0] wd, input logic [13:0] ra, input int lag);
    i_erb_fabric_model.access(we, re, wa, wd, ra, lag, d, s);
  endtask : acc
  task automatic clr(input logic [71:0] ed, input logic [2:0] es);
    @(posedge ref_clk);
    outClr <= 1'b1;
    #1;
    chk(rdData, ed);
    chk(eccStatus, es);
    @(posedge ref_clk);
    outClr <= 1'b0;
  endtask : clr
  task automatic test_reset();
    chk(rdData, 72'h0);
    chk(eccStatus, 3'h0);
    reg_rd(4'h0, r);
    chk(r, 32'h0);
    reg_wr(4'h8, 32'hFFFF_FFFF);
    reg_rd(4'h8, r);
    chk(r, 32'h0);
    $display("test reset done");
  endtask : test_reset
  task automatic test_ecc();
    reg_wr(4'h0, 32'h0000_014E);
    reg_rd(4'h4, r);
    chk(r[0], 1'b0);
    reg_wr(4'h0, ECC);
    reg_rd(4'h4, r);
    chk(r[0], 1'b1);
    acc(1'b1, 1'b0, 14'h0, DW, 14'h0, 0);
    acc(1'b0, 1'b1, 14'h0, 72'h0, 14'h0, 1);
    chk(d, DW);
    chk(s, 3'h0);
    reg_wr(4'h0, 32'h0000_01F6);
    acc(1'b0, 1'b1, 14'h0, 72'h0, 14'h0, 1);
    cw = d;
    acc(1'b1, 1'b0, 14'h1, cw ^ 72'h1, 14'h0, 0);
    acc(1'b1, 1'b0, 14'h2, cw ^ 72'h3, 14'h0, 0);
    reg_wr(4'h0, ECC);
    acc(1'b0, 1'b1, 14'h0, 72'h0, 14'h1, 1);
    chk(d, DW);
    chk(s, 3'h3);
    acc(1'b0, 1'b1, 14'h0, 72'h0, 14'h2, 1);
    chk(s, 3'h5);
    reg_rd(4'h4, r);
    chk(r[3:0], 4'hD);
    reg_wr(4'h4, 32'h0000_000C);
    reg_rd(4'h4, r);
    chk(r[3:0], 4'h1);
    $display("test ecc done");
  endtask : test_ecc
  task automatic test_outreg();
    reg_wr(4'h0, ECC | 32'h0000_0600);
    clr(72'h0, 3'h0);
    acc(1'b0, 1'b1, 14'h0, 72'h0, 14'h1, 1);
    chk(d, 72'h0);
    chk(s, 3'h5);
    @(posedge ref_clk);
    #1;
    chk(rdData, DW);
    chk(eccStatus, 3'h3);
    clr(72'h0, 3'h0);
    reg_wr(4'h0, ECC);
    acc(1'b0, 1'b1, 14'h0, 72'h0, 14'h1, 1);
    clr(72'h0, 3'h3);
    $display("test outreg done");
  endtask : test_outreg
  task automatic test_rdw();
    reg_wr(4'h0, 32'h0000_09E6);
    acc(1'b1, 1'b0, 14'h7, DW, 14'h0, 0);
    acc(1'b1, 1'b1, 14'h7, DE, 14'h7, 1);
    chk(d, DW);
    acc(1'b1, 1'b1, 14'h8, DW, 14'h7, 1);
    chk(d, DE);
    acc(1'b0, 1'b1, 14'h0, 72'h0, 14'h8, 1);
    chk(d, DW);
    reg_wr(4'h0, 32'h0000_09EE);
    acc(1'b1, 1'b1, 14'h7, DW, 14'h7, 1);
    chk(d, 72'h0);
    $display("test rdw done");
  endtask : test_rdw
  task automatic test_sp();
    reg_wr(4'h0, 32'h0000_1141);
    acc(1'b1, 1'b0, 14'h3, 72'h1111_2222, 14'h0, 0);
    acc(1'b0, 1'b1, 14'h3, 72'h0, 14'h0, 1);
    chk(d, 72'h1111_2222);
    acc(1'b1, 1'b0, 14'h3, 72'h3333_4444, 14'h0, 1);
    chk(d, 72'h1111_2222);
    acc(1'b1, 1'b1, 14'h3, 72'h5555_6666, 14'h0, 1);
    chk(d, 72'h5555_6666);
    reg_wr(4'h0, 32'h0000_01E1);
    reg_rd(4'h4, r);
    chk(r[1], 1'b1);
    reg_wr(4'h0, 32'h0000_00A0);
    acc(1'b1, 1'b0, 14'h2, 72'hBEEF, 14'h0, 0);
    acc(1'b0, 1'b0, 14'h2, 72'h0, 14'h0, 0);
    chk(d, 72'hBEEF);
    $display("test single-port done");
  endtask : test_sp
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      complete_run();
    end
  end
  initial begin
    reset_n = 1'b0;
    outClr = 1'b0;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 4'h0;
    regWrData = 32'h0;
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    test_reset();
    test_ecc();
    test_outreg();
    test_rdw();
    test_sp();
    complete_run();
  end
endmodule : erb_ram_top_test
